// [acsop_consts.vh]
// Constants for the converter serial output port
// Summary of operation
// - Early deselect self-clocked: finish bit, float
// - External mode: select ignored during ready-high
// - External mode shifts on clock falling edge
// - Async mode finishes packet after deselect
// - Load each result unless port transmitting
// - Three-level mode input selects port mode
// - Cycle 1024; ready rises 1020, high four
// - Self-clocked clock quarter rate, MSB first
// - Async: two 11-bit packets, LSB first
`ifndef ACSOP_CONSTS_VH
`define ACSOP_CONSTS_VH
`define ACSOP_WORD_BITS 16
`define ACSOP_CYCLE_LEN 11'd1024
`define ACSOP_READY_RISE 11'd1020
`define ACSOP_FIRST_POLL 11'd76
`define ACSOP_POLL_STEP 7'h7f
`define ACSOP_POLL_OFS 7'h4b
`define ACSOP_MODE_SELF 2'd0
`define ACSOP_MODE_EXT 2'd1
`define ACSOP_MODE_ASYNC 2'd2
`define ACSOP_PACKET_BITS 4'd11
`endif

// [acsop_shift_reg.v]
// Output word holding register with load and shift
`default_nettype none
`include "acsop_consts.vh"
module acsop_shift_reg
(
	input  wire                        clk,
	input  wire                        rst,
	input  wire                        load,
	input  wire [`ACSOP_WORD_BITS-1:0] loadData,
	input  wire                        shift,
	output reg  [`ACSOP_WORD_BITS-1:0] word
);
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			word <= {`ACSOP_WORD_BITS{1'b0}};
		else if (load)
			word <= loadData;
		else if (shift)
			word <= {word[`ACSOP_WORD_BITS-2:0], 1'b0};
	end
endmodule
`default_nettype wire

// [acsop_serial_port.v]
// Serial output port with self, external and async modes
`default_nettype none
`include "acsop_consts.vh"
module acsop_serial_port
(
	input  wire                        ref_clk,
	input  wire                        rst,
	input  wire [1:0]                  portMode,
	input  wire [`ACSOP_WORD_BITS-1:0] resultData,
	input  wire                        portSelectN,
	input  wire                        serialClockIn,
	output reg                         dataReadyN,
	output reg                         serialDataOut,
	output reg                         serialDataOe,
	output reg                         serialClockOut,
	output reg                         serialClockOe
);
	localparam IDLE = 2'd0;
	localparam SEND = 2'd1;
	localparam DONE = 2'd2;
	reg [1:0] csSync;
	reg [1:0] sckSync;
	reg       sckLast;
	reg [10:0] cycleCount;
	reg [1:0]  state;
	reg [4:0]  bitCount;
	reg [1:0]  divCount;
	reg        aborting;
	reg        secondPacket;
	reg [10:0] packet;
	reg        wordTaken;
	wire [`ACSOP_WORD_BITS-1:0] word;
	wire csLow = ~csSync[1];
	wire sckFall = sckLast & ~sckSync[1];
	wire readyHigh = cycleCount >= `ACSOP_READY_RISE;
	wire atUpdate = cycleCount == `ACSOP_CYCLE_LEN - 11'd1;
	wire pollTime = cycleCount >= `ACSOP_FIRST_POLL - 11'd1 &&
		(cycleCount[6:0] == `ACSOP_POLL_OFS);
	wire busy = state != IDLE || wordTaken;
	wire doLoad = atUpdate && !busy;
	wire doShift = (state == SEND) && (
		(portMode == `ACSOP_MODE_SELF && divCount == 2'd3) ||
		(portMode == `ACSOP_MODE_EXT && sckFall));
	acsop_shift_reg shifter
	(
		.clk      (ref_clk),
		.rst      (rst),
		.load     (doLoad),
		.loadData (resultData),
		.shift    (doShift),
		.word     (word)
	);
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			csSync <= 2'b11;
			sckSync <= 2'b00;
			sckLast <= 1'b0;
		end
		else
		begin
			csSync <= {csSync[0], portSelectN};
			sckSync <= {sckSync[0], serialClockIn};
			sckLast <= sckSync[1];
		end
	end
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			cycleCount <= 11'd0;
		else if (atUpdate)
			cycleCount <= 11'd0;
		else
			cycleCount <= cycleCount + 11'd1;
	end
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= IDLE;
			bitCount <= 5'd0;
			divCount <= 2'd0;
			aborting <= 1'b0;
			secondPacket <= 1'b0;
			packet <= 11'h7ff;
			wordTaken <= 1'b0;
			dataReadyN <= 1'b1;
			serialDataOut <= 1'b0;
			serialDataOe <= 1'b0;
			serialClockOut <= 1'b0;
			serialClockOe <= 1'b0;
		end
		else
		begin
			if (doLoad)
				dataReadyN <= 1'b0;
			else if (cycleCount == `ACSOP_READY_RISE - 11'd1 && !busy)
				dataReadyN <= 1'b1;
			if (atUpdate)
				wordTaken <= 1'b0;
			case (state)
			IDLE:
			begin
				serialDataOe <= 1'b0;
				serialClockOe <= 1'b0;
				serialClockOut <= 1'b0;
				divCount <= 2'd0;
				aborting <= 1'b0;
				if (portMode == `ACSOP_MODE_SELF && csLow && pollTime && !dataReadyN)
				begin
					state <= SEND;
					bitCount <= 5'd0;
					serialDataOe <= 1'b1;
					serialClockOe <= 1'b1;
					serialDataOut <= word[`ACSOP_WORD_BITS-1];
				end
				else if (portMode == `ACSOP_MODE_EXT && csLow && !readyHigh && !dataReadyN)
				begin
					state <= SEND;
					bitCount <= 5'd0;
					serialDataOe <= 1'b1;
					serialDataOut <= word[`ACSOP_WORD_BITS-1];
				end
				else if (portMode == `ACSOP_MODE_ASYNC && csLow && sckFall && !dataReadyN)
				begin
					state <= SEND;
					bitCount <= 5'd0;
					serialDataOe <= 1'b1;
					serialDataOut <= 1'b0;
					packet <= secondPacket ? {2'b11, word[7:0], 1'b0} :
						{2'b11, word[15:8], 1'b0};
				end
			end
			SEND:
			begin
				if (portMode == `ACSOP_MODE_SELF)
				begin
					divCount <= divCount + 2'd1;
					serialClockOut <= divCount == 2'd1 || divCount == 2'd2;
					if (!csLow)
						aborting <= 1'b1;
					if (divCount == 2'd3)
					begin
						if (aborting || !csLow || bitCount == `ACSOP_WORD_BITS - 1)
							state <= DONE;
						else
							serialDataOut <= word[`ACSOP_WORD_BITS-2];
						bitCount <= bitCount + 5'd1;
					end
				end
				else if (portMode == `ACSOP_MODE_EXT)
				begin
					if (!csLow)
					begin
						serialDataOe <= 1'b0;
						state <= IDLE;
					end
					else if (sckFall)
					begin
						if (bitCount == `ACSOP_WORD_BITS - 1)
							state <= DONE;
						else
							serialDataOut <= word[`ACSOP_WORD_BITS-2];
						bitCount <= bitCount + 5'd1;
					end
				end
				else if (sckFall)
				begin
					if (bitCount == {1'b0, `ACSOP_PACKET_BITS} - 5'd1)
					begin
						state <= DONE;
						secondPacket <= ~secondPacket;
					end
					else
						serialDataOut <= packet[bitCount[3:0] + 4'd1];
					bitCount <= bitCount + 5'd1;
				end
			end
			default:
			begin
				serialDataOe <= 1'b0;
				serialClockOe <= 1'b0;
				serialClockOut <= 1'b0;
				if (portMode != `ACSOP_MODE_ASYNC || secondPacket == 1'b0)
					dataReadyN <= 1'b1;
				if (portMode != `ACSOP_MODE_ASYNC || secondPacket == 1'b0)
					wordTaken <= 1'b0;
				state <= IDLE;
			end
			endcase
			if (state == SEND && !doLoad)
				wordTaken <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// [acsop_properties.sv]
// Checker for the serial output port
`default_nettype none
`include "acsop_consts.vh"
module acsop_props
(
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic [1:0] portMode,
	input wire logic       portSelectN,
	input wire logic       serialClockIn,
	input wire logic       dataReadyN,
	input wire logic       serialDataOut,
	input wire logic       serialDataOe,
	input wire logic       serialClockOut,
	input wire logic       serialClockOe
);
	logic [3:0] age;
	wire logic  ext = portMode == `ACSOP_MODE_EXT;
	wire logic  slf = portMode == `ACSOP_MODE_SELF;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Cycles since the host clock last fell
	always @(posedge ref_clk)
		age <= rst ? 4'hf : ($past(serialClockIn) & ~serialClockIn) ? 4'h0 : age + {3'h0, age != 4'hf};
	sequence clkHigh2;
		##1 serialClockOut ##1 !serialClockOut;
	endsequence
	chk_ready_low_hold: assert property ($fell(dataReadyN) |-> !dataReadyN [*8])
		else $error("ready low too short");
	chk_clock_self_only: assert property (serialClockOe |-> slf)
		else $error("clock driven outside self mode");
	chk_clock_quarter: assert property (serialClockOe && $rose(serialClockOut) |-> clkHigh2)
		else $error("clock high time wrong");
	chk_clock_with_data: assert property (serialClockOe |-> serialDataOe)
		else $error("clock driven without data");
	chk_ext_fall_shift: assert property (ext && serialDataOe && $past(serialDataOe) && $changed(serialDataOut) |-> age < 4'h6)
		else $error("data moved without a host clock fall");
	chk_ext_select_gate: assert property (ext && $rose(serialDataOe) |-> $past(dataReadyN) == 1'b0)
		else $error("select taken while ready high");
	chk_self_early_float: assert property (slf && $rose(portSelectN) |-> ##[1:12] !serialDataOe && !serialClockOe)
		else $error("outputs not floated after deselect");
	chk_ext_deselect: assert property (ext && $rose(portSelectN) |-> ##[1:4] !serialDataOe)
		else $error("data not floated after deselect");
endmodule
`default_nettype wire

// [acsop_host_model.sv]
// Host model that clocks words out of the port
`default_nettype none
module acsop_host_model
(
	input  wire logic        start,
	input  wire logic [4:0]  nRise,
	input  wire logic        sdLine,
	output var  logic        selN,
	output var  logic        sclk,
	output var  logic [21:0] got
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		selN = 1'b1;
		sclk = 1'b0;
		got = 22'h0;
	end
	always @(posedge start)
	begin
		got = 22'h0;
		selN = 1'b0;
		#240;
		repeat (nRise)
		begin
			sclk = 1'b1;
			got = {got[20:0], sdLine};
			#80;
			sclk = 1'b0;
			#80;
		end
		selN = 1'b1;
	end
endmodule
`default_nettype wire

// [tb_top.sv]
// Testbench for the serial output port
`default_nettype none
`include "acsop_consts.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 1'b0, rst = 1'b1, start = 1'b0, tbSel = 1'b1, lastSd = 1'b0;
	logic [1:0]  portMode = `ACSOP_MODE_EXT;
	logic [15:0] resultData = 16'ha5c3;
	logic [4:0]  nRise = 5'h10;
	logic [21:0] got;
	logic        hostSel, serialClockIn, dataReadyN, serialDataOut, serialDataOe, serialClockOut, serialClockOe;
	int          failures = 0, checks = 0;
	wire logic   portSelectN = hostSel & tbSel;
	wire logic   sdLine = serialDataOe ? serialDataOut : ~lastSd;
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (serialDataOe) lastSd <= serialDataOut;
	acsop_serial_port dut_u (.ref_clk, .rst, .portMode, .resultData, .portSelectN, .serialClockIn,
		.dataReadyN, .serialDataOut, .serialDataOe, .serialClockOut, .serialClockOe);
	acsop_host_model host_u (.start, .nRise, .sdLine, .selN(hostSel), .sclk(serialClockIn), .got);
	task automatic cmp(input string what, input logic [21:0] exp, input logic [21:0] seen);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic summarize;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic doReset(input logic [1:0] m);
		rst = 1'b1;
		portMode = m;
		repeat (3) tick();
		rst = 1'b0;
	endtask
	task automatic waitRdy(input logic lvl);
		int n;
		for (n = 0; dataReadyN !== lvl && n < 2100; n++) tick();
	endtask
	task automatic tReady;
		int lo, hi;
		waitRdy(1'b1);
		waitRdy(1'b0);
		for (lo = 0; dataReadyN === 1'b0 && lo < 2000; lo++) tick();
		for (hi = 0; dataReadyN === 1'b1 && hi < 20; hi++) tick();
		cmp("ready low cycles", 22'd1020, lo[21:0]);
		cmp("ready high cycles", 22'd4, hi[21:0]);
	endtask
	task automatic tRead(input logic [21:0] exp);
		start = 1'b1;
		#160;
		start = 1'b0;
		wait (hostSel === 1'b1);
		cmp("host word", exp, got);
	endtask
	task automatic tSelf;
		logic [21:0] w;
		logic        pc;
		int          n, b;
		w = 22'h0;
		pc = 1'b0;
		b = 0;
		tbSel = 1'b0;
		for (n = 0; b < 16 && n < 3000; n++)
		begin
			tick();
			if (serialClockOe === 1'b1 && serialClockOut === 1'b1 && !pc)
			begin
				w = {w[20:0], serialDataOut};
				b++;
			end
			pc = serialClockOut;
		end
		tbSel = 1'b1;
		cmp("self word", 22'h00a5c3, w);
		repeat (8) tick();
		tbSel = 1'b0;
		for (n = 0; serialClockOe !== 1'b1 && n < 3000; n++) tick();
		repeat (9) tick();
		tbSel = 1'b1;
		repeat (12) tick();
		cmp("self float", {20'h0, serialDataOe, serialClockOe}, 22'h0);
	endtask
	initial
	begin
		doReset(`ACSOP_MODE_EXT);
		tReady();
		waitRdy(1'b0);
		tRead(22'h00a5c3);
		waitRdy(1'b0);
		waitRdy(1'b1);
		resultData = 16'h3c96;
		tRead(22'h003c96);
		doReset(`ACSOP_MODE_SELF);
		resultData = 16'ha5c3;
		tSelf();
		resultData = 16'h12c5;
		doReset(`ACSOP_MODE_ASYNC);
		nRise = 5'd23;
		waitRdy(1'b0);
		waitRdy(1'b1);
		waitRdy(1'b0);
		// Packet one, one floated bit, then start, data and first stop of packet two
		tRead({1'b0, 8'h48, 2'b11, 1'b0, 1'b0, 8'ha3, 1'b1});
		summarize();
	end
	initial
	begin
		#1000000;
		failures++;
		summarize();
	end
endmodule
bind acsop_serial_port acsop_props chk_u (.ref_clk, .rst, .portMode, .portSelectN, .serialClockIn,
	.dataReadyN, .serialDataOut, .serialDataOe, .serialClockOut, .serialClockOe);
`default_nettype wire
